// ---- rtl/system_reset_sequencer.sv ----
// Reset source collector and system reset sequencer.
// Assumes supply comparators and the reset pin are asynchronous; watchdog on sys_clk.
// What this block does
// - Any of power-on, pin, brown-out or watchdog starts a system reset.
// - Core halted during sequence; run from code memory when it ends.
// - All mapped registers and I/O return to defaults; SRAM not touched.
// - Sequence length depends on which source triggered it.
// - I/O lines 1,2,3,4,6,7 become high-impedance inputs.
// - I/O lines 0 and 5 take the state in fourth init register.
// - Load stack 0xF, status 0x80, PWM registers 0xFFF, dead time 0x1F.
// - Every other mapped register clears to zero.
// - Power-on holds reset until supply good; also resets when supply good falls.
// - Brown-out acts only when its enable bit is set.
// - Stay in reset during low supply; start sequence after recovery.
// - While pin low with supply good, analog and oscillator low-power, I/O at defaults.
// - Pin rising edge releases analog and starts the sequence.
`timescale 1ns/10ps
module system_reset_sequencer
  import rst_seq_pkg::*;
#(
  parameter int SEQ_POR = SEQ_POR_CYC,
  parameter int SEQ_EXT = SEQ_EXT_CYC,
  parameter int SEQ_BOR = SEQ_BOR_CYC,
  parameter int SEQ_WDT = SEQ_WDT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Reset sources
  input wire logic powerGood,
  input wire logic extReset_n,
  input wire logic brownout_detect,
  input wire logic brownout_enable,
  input wire logic watchdogTimeout,
  // Init register 4 defaults for lines 0 and 5
  input wire logic [7:0] ioInitOut,
  input wire logic [7:0] ioInitOe,
  // To core and register file
  output logic sysReset_r,
  output logic coreHalt_r,
  output logic loadDefaults_r,
  output rst_seq_pkg::defaults_t regDefaults_r,
  output rst_seq_pkg::io_t ioDefault_r,
  output logic analogLowPower_r,
  output rst_seq_pkg::src_t lastSource_r
);
  import rst_seq_pkg::*;

  typedef enum logic [1:0] {ST_HOLD, ST_SEQ, ST_RUN} state_t;

  // Two-flop synchronisers for the asynchronous inputs
  logic [2:0] syncA_r;
  logic [2:0] syncB_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // Pin stage starts at its pulled-up idle level so no false pin reset follows
      syncA_r <= 3'h2;
      syncB_r <= 3'h2;
    end else begin
      syncA_r <= {powerGood, extReset_n, brownout_detect};
      syncB_r <= syncA_r;
    end
  end
  logic pwrOk;
  logic pinHigh;
  logic borLow;
  assign pwrOk = syncB_r[2];
  assign pinHigh = syncB_r[1];
  assign borLow = syncB_r[0] & brownout_enable;

  function automatic logic [CNT_W-1:0] seqLen(input src_t s);
    case (s)
      SRC_POR: seqLen = CNT_W'(SEQ_POR);
      SRC_EXT: seqLen = CNT_W'(SEQ_EXT);
      SRC_BOR: seqLen = CNT_W'(SEQ_BOR);
      SRC_WDT: seqLen = CNT_W'(SEQ_WDT);
      default: seqLen = CNT_W'(SEQ_POR);
    endcase
  endfunction

  state_t state_r;
  state_t state_nxt;
  src_t src_r;
  src_t src_nxt;
  logic load;
  logic done;
  logic holding;

  // Level sources hold; the sequence starts when all held sources are gone
  assign holding = !pwrOk || !pinHigh || borLow;

  seq_counter #(.W(CNT_W)) uCnt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(load),
    .length(seqLen(src_nxt)),
    .done(done)
  );

  always_comb begin
    state_nxt = state_r;
    src_nxt = src_r;
    load = 1'b0;
    if (!pwrOk) begin
      src_nxt = SRC_POR;
    end else if (borLow) begin
      src_nxt = SRC_BOR;
    end else if (!pinHigh) begin
      src_nxt = SRC_EXT;
    end
    case (state_r)
      ST_HOLD: begin
        if (!holding) begin
          state_nxt = ST_SEQ;
          load = 1'b1;
        end
      end
      ST_SEQ: begin
        if (holding) begin
          state_nxt = ST_HOLD;
        end else if (watchdogTimeout) begin
          src_nxt = SRC_WDT;
          load = 1'b1;
        end else if (done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (holding) begin
          state_nxt = ST_HOLD;
        end else if (watchdogTimeout) begin
          src_nxt = SRC_WDT;
          state_nxt = ST_SEQ;
          load = 1'b1;
        end
      end
      default: state_nxt = ST_HOLD;
    endcase
  end

  logic sysReset_nxt;
  logic analog_nxt;
  io_t io_nxt;
  defaults_t def_nxt;
  always_comb begin
    sysReset_nxt = (state_nxt != ST_RUN);
    analog_nxt = (state_nxt == ST_HOLD) && !pinHigh && pwrOk;
    // Lines 0 and 5 follow init register 4, the rest float as inputs
    io_nxt.ioOut = ioInitOut & IO_INIT_MASK;
    io_nxt.ioOe = ioInitOe & IO_INIT_MASK & ~IO_INPUT_MASK;
    def_nxt.stackPtr = SP_RST;
    def_nxt.status = STATUS_RST;
    def_nxt.pwmCompareA = PWM_RST;
    def_nxt.pwmCompareB = PWM_RST;
    def_nxt.pwmPeriodReload = PWM_RST;
    def_nxt.deadTimeValue = DEADTIME_RST;
    def_nxt.otherReg = OTHER_RST;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_HOLD;
      src_r <= SRC_POR;
      sysReset_r <= 1'b1;
      coreHalt_r <= 1'b1;
      loadDefaults_r <= 1'b1;
      analogLowPower_r <= 1'b0;
      ioDefault_r <= '0;
      // Defaults must already be valid while loadDefaults_r is high in reset
      regDefaults_r <= '{SP_RST, STATUS_RST, PWM_RST, PWM_RST, PWM_RST, DEADTIME_RST, OTHER_RST};
      lastSource_r <= SRC_POR;
    end else begin
      state_r <= state_nxt;
      src_r <= src_nxt;
      sysReset_r <= sysReset_nxt;
      coreHalt_r <= sysReset_nxt;
      // Defaults are forced for the whole reset; SRAM has no port here, so it is kept
      loadDefaults_r <= sysReset_nxt;
      analogLowPower_r <= analog_nxt;
      ioDefault_r <= io_nxt;
      regDefaults_r <= def_nxt;
      lastSource_r <= src_nxt;
    end
  end

  property p_hold_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      (!pwrOk || borLow) |=> sysReset_r;
  endproperty
  a_hold_reset: assert property (p_hold_reset)
    else $error("reset dropped during low supply");

  property p_bor_gate;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r == ST_RUN && !brownout_enable && pwrOk && pinHigh && !watchdogTimeout)
      |=> !sysReset_r;
  endproperty
  a_bor_gate: assert property (p_bor_gate)
    else $error("disabled brown-out caused reset");

  property p_wdt;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_r == ST_RUN && watchdogTimeout) |=> (sysReset_r && lastSource_r == SRC_WDT);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not reset");

  property p_halt;
    @(posedge sys_clk) disable iff (!rst_n) coreHalt_r == sysReset_r;
  endproperty
  a_halt: assert property (p_halt) else $error("core not halted in reset");

  property p_io;
    @(posedge sys_clk) disable iff (!rst_n)
      sysReset_r |-> (ioDefault_r.ioOe & IO_INPUT_MASK) == 8'h00;
  endproperty
  a_io: assert property (p_io) else $error("input lines driven in reset");

  property p_vals;
    @(posedge sys_clk) disable iff (!rst_n) $past(rst_n) |-> (regDefaults_r.status == 8'h80
      && regDefaults_r.pwmPeriodReload == 12'hFFF && regDefaults_r.deadTimeValue == 5'h1F);
  endproperty
  a_vals: assert property (p_vals) else $error("wrong default values");

  property p_pin_low;
    @(posedge sys_clk) disable iff (!rst_n) (!pinHigh && pwrOk) |=> analogLowPower_r;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("no low power while pin low");

  property p_release;
    @(posedge sys_clk) disable iff (!rst_n)
      $fell(sysReset_r) |-> $past(state_r) == ST_SEQ;
  endproperty
  a_release: assert property (p_release) else $error("release without sequence");
endmodule

// ---- rtl/rst_seq_pkg.sv ----
// Package for the system reset sequencer: timing, default values, carriers.
// Assumes a single 20 MHz system clock.
package rst_seq_pkg;
  localparam int CLK_MHZ = 20;
  // External pin low time, microseconds, and its cycle count (least time, rounded up)
  localparam int EXT_LOW_US = 10;
  localparam int EXT_LOW_CYC = EXT_LOW_US * CLK_MHZ;
  // Sequence lengths per source, in cycles (plain defaults)
  localparam int SEQ_POR_CYC = 4000;
  localparam int SEQ_EXT_CYC = 2000;
  localparam int SEQ_BOR_CYC = 3000;
  localparam int SEQ_WDT_CYC = 1000;
  localparam int CNT_W = 16;
  // Register defaults loaded on any reset
  localparam logic [3:0] SP_RST = 4'hF;
  localparam logic [7:0] STATUS_RST = 8'h80;
  localparam logic [11:0] PWM_RST = 12'hFFF;
  localparam logic [4:0] DEADTIME_RST = 5'h1F;
  localparam logic [7:0] OTHER_RST = 8'h00;
  localparam logic [7:0] IO_INPUT_MASK = 8'hDE;
  localparam logic [7:0] IO_INIT_MASK = 8'h21;

  typedef enum logic [1:0] {SRC_POR, SRC_EXT, SRC_BOR, SRC_WDT} src_t;

  typedef struct packed {
    logic [3:0] stackPtr;
    logic [7:0] status;
    logic [11:0] pwmCompareA;
    logic [11:0] pwmCompareB;
    logic [11:0] pwmPeriodReload;
    logic [4:0] deadTimeValue;
    logic [7:0] otherReg;
  } defaults_t;

  typedef struct packed {
    logic [7:0] ioOut;
    logic [7:0] ioOe;
  } io_t;
endpackage

// ---- rtl/seq_counter.sv ----
// Down-counter that times one reset sequence.
// Assumes load and length come from the same clock domain.
`timescale 1ns/10ps
module seq_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [W-1:0] length,
  // Status
  output logic done
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = done_r;
    if (load) begin
      cnt_nxt = length;
      done_nxt = 1'b0;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
      done_nxt = (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule

// ---- sim/rst_src_model.sv ----
// Model of the reset pin driver and the supply monitors.
// Assumes one bench process calls its tasks at a time.
`timescale 1ns/10ps
module rst_src_model
  import rst_seq_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Sources
  output logic powerGood,
  output logic extReset_n,
  output logic brownout_detect,
  output logic watchdogTimeout
);
  initial begin
    powerGood = 1'b0;
    extReset_n = 1'b1; // Pull-up holds it high when undriven
    brownout_detect = 1'b0;
    watchdogTimeout = 1'b0;
  end
  task automatic supply_up();
    @(posedge sys_clk) powerGood <= 1'b1;
  endtask
  // Never shorter than the least low time; extra makes a slow release
  task automatic pin_reset(input int extra);
    @(posedge sys_clk) extReset_n <= 1'b0;
    repeat (EXT_LOW_CYC + extra) @(posedge sys_clk);
    extReset_n <= 1'b1;
  endtask
  task automatic brownout(input int n);
    @(posedge sys_clk) brownout_detect <= 1'b1;
    repeat (n) @(posedge sys_clk);
    brownout_detect <= 1'b0;
  endtask
  task automatic wdt_pulse();
    @(posedge sys_clk) watchdogTimeout <= 1'b1;
    @(posedge sys_clk) watchdogTimeout <= 1'b0;
  endtask
endmodule

// ---- sim/system_reset_sequencer_tb_top.sv ----
// Self-checking bench for the system reset sequencer.
// Assumes short sequence lengths; sources come from the model.
`timescale 1ns/10ps
module system_reset_sequencer_tb_top;
  import rst_seq_pkg::*;
  localparam int L_POR = 20;
  localparam int L_EXT = 12;
  localparam int L_BOR = 16;
  localparam int L_WDT = 8;
  typedef struct {src_t src; int len; int t0;} note_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic brownout_enable = 1'b0;
  logic [7:0] ioInitOut = 8'h00;
  logic [7:0] ioInitOe = 8'h00;
  logic powerGood, extReset_n, brownout_detect, watchdogTimeout;
  logic sysReset_r, coreHalt_r, loadDefaults_r, analogLowPower_r;
  logic prevRst = 1'b1;
  defaults_t regDefaults_r;
  io_t ioDefault_r;
  src_t lastSource_r;
  note_t notes[$];
  note_t n;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  always #25 sys_clk = ~sys_clk;
  rst_src_model model_u (.sys_clk, .powerGood, .extReset_n, .brownout_detect, .watchdogTimeout);
  system_reset_sequencer #(.SEQ_POR(L_POR), .SEQ_EXT(L_EXT), .SEQ_BOR(L_BOR),
    .SEQ_WDT(L_WDT)) dut_u (.sys_clk, .rst_n, .powerGood, .extReset_n, .brownout_detect,
    .brownout_enable, .watchdogTimeout, .ioInitOut, .ioInitOe, .sysReset_r, .coreHalt_r,
    .loadDefaults_r, .regDefaults_r, .ioDefault_r, .analogLowPower_r, .lastSource_r);
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic expect_seq(input src_t s, input int l);
    notes.push_back('{s, l, cyc});
  endtask
  task automatic settle();
    int k;
    for (k = 0; k < 300 && notes.size() != 0; k++) @(posedge sys_clk);
    if (notes.size() != 0) check(notes.size(), 0);
    repeat (5) @(posedge sys_clk);
  endtask
  // Outputs are looked at on the falling edge, clear of the launch edge
  always @(negedge sys_clk) begin
    cyc = cyc + 1;
    if (rst_n && sysReset_r === 1'b1) begin
      check(coreHalt_r, 1'b1);
      check(loadDefaults_r, 1'b1);
      check(regDefaults_r,
        {SP_RST, STATUS_RST, {3{PWM_RST}}, DEADTIME_RST, OTHER_RST});
      check({ioDefault_r.ioOut & IO_INIT_MASK, ioDefault_r.ioOe},
        {ioInitOut & IO_INIT_MASK, ioInitOe & IO_INIT_MASK});
    end
    if (rst_n && prevRst === 1'b1 && sysReset_r === 1'b0) begin
      if (notes.size() == 0) check(1'b1, 1'b0);
      else begin
        n = notes.pop_front();
        check(lastSource_r, n.src);
        check((cyc - n.t0) >= n.len && (cyc - n.t0) <= n.len + 8, 1'b1);
      end
    end
    prevRst = sysReset_r;
  end
  initial begin
    void'($urandom(12));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (30) @(posedge sys_clk);
    @(negedge sys_clk) check(sysReset_r, 1'b1);
    model_u.supply_up();
    expect_seq(SRC_POR, L_POR);
    settle();
    for (int i = 0; i < 2; i++) begin
      ioInitOut <= 8'($urandom);
      ioInitOe <= 8'($urandom);
      fork
        model_u.pin_reset(i * 50);
        begin
          repeat (20) @(posedge sys_clk);
          @(negedge sys_clk) check(analogLowPower_r, 1'b1);
          check(sysReset_r, 1'b1);
        end
      join
      expect_seq(SRC_EXT, L_EXT);
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk) check(analogLowPower_r, 1'b0);
      settle();
    end
    model_u.brownout(20 + $urandom % 20);
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk) check(sysReset_r, 1'b0);
    @(posedge sys_clk) brownout_enable <= 1'b1;
    fork
      model_u.brownout(20 + $urandom % 20);
      begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk) check(sysReset_r, 1'b1);
      end
    join
    expect_seq(SRC_BOR, L_BOR);
    settle();
    model_u.wdt_pulse();
    expect_seq(SRC_WDT, L_WDT);
    settle();
    // A second timeout mid-sequence restarts the count
    model_u.wdt_pulse();
    repeat (4) @(posedge sys_clk);
    model_u.wdt_pulse();
    expect_seq(SRC_WDT, L_WDT);
    settle();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    test_done();
  end
endmodule
